// *** rtl/psfs_consts.vh ***
// Register offsets, reset values and code constants of the pin function select block.
// Included by the design files; no logic lives here.
`ifndef PSFS_CONSTS_VH
`define PSFS_CONSTS_VH
`define PSFS_OFF_IRS_B 4'h0
`define PSFS_OFF_IRS_C 4'h1
`define PSFS_OFF_PA_LO 4'h2
`define PSFS_OFF_PA_HI 4'h3
`define PSFS_OFF_PB_LO 4'h4
`define PSFS_OFF_PB_HI 4'h5
`define PSFS_OFF_PC_LO 4'h6
`define PSFS_OFF_PC_HI 4'h7
`define PSFS_OFF_PA_DATA 4'h8
`define PSFS_OFF_PA_DIR 4'h9
`define PSFS_OFF_PB_DATA 4'hA
`define PSFS_OFF_PB_DIR 4'hB
`define PSFS_OFF_PC_DATA 4'hC
`define PSFS_OFF_PC_DIR 4'hD
`define PSFS_OFF_PA_WAKE 4'hE
`define PSFS_OFF_PINS 4'hF
`define PSFS_SEL_RST 8'h00
`define PSFS_PORT_RST 8'hFF
`define PSFS_WAKE_RST 8'h00
`define PSFS_IRS_C_MASK 8'h03
`define PSFS_PC_HI_MASK 8'h0F
`define PSFS_PC_MASK 8'h3F
`define PSFS_C00 2'b00
`define PSFS_C01 2'b01
`define PSFS_C10 2'b10
`define PSFS_C11 2'b11
`endif

// *** rtl/psfs_regs.v ***
// Select and port register file with registered read data.
// Assumes one-cycle write and read strobes, never both at once.
`timescale 1ns/10ps
`default_nettype none
`include "psfs_consts.vh"
module psfs_regs
(
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] pins_a,
  input wire [7:0] pins_b,
  input wire [7:0] pins_c,
  output reg [7:0] rdata,
  output reg [7:0] irs_b,
  output reg [7:0] irs_c,
  output reg [7:0] pa_lo,
  output reg [7:0] pa_hi,
  output reg [7:0] pb_lo,
  output reg [7:0] pb_hi,
  output reg [7:0] pc_lo,
  output reg [7:0] pc_hi,
  output reg [7:0] pa_data,
  output reg [7:0] pa_dir,
  output reg [7:0] pb_data,
  output reg [7:0] pb_dir,
  output reg [7:0] pc_data,
  output reg [7:0] pc_dir,
  output reg [7:0] pa_wake
);
  // ==========================================================
  // Writes
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      irs_b <= `PSFS_SEL_RST;
      irs_c <= `PSFS_SEL_RST;
      pa_lo <= `PSFS_SEL_RST;
      pa_hi <= `PSFS_SEL_RST;
      pb_lo <= `PSFS_SEL_RST;
      pb_hi <= `PSFS_SEL_RST;
      pc_lo <= `PSFS_SEL_RST;
      pc_hi <= `PSFS_SEL_RST;
      pa_data <= `PSFS_PORT_RST;
      pa_dir <= `PSFS_PORT_RST;
      pb_data <= `PSFS_PORT_RST;
      pb_dir <= `PSFS_PORT_RST;
      pc_data <= `PSFS_PC_MASK;
      pc_dir <= `PSFS_PC_MASK;
      pa_wake <= `PSFS_WAKE_RST;
    end
    else if (wr)
    begin
      case (addr)
        `PSFS_OFF_IRS_B: irs_b <= wdata;
        `PSFS_OFF_IRS_C: irs_c <= wdata & `PSFS_IRS_C_MASK;
        `PSFS_OFF_PA_LO: pa_lo <= wdata;
        `PSFS_OFF_PA_HI: pa_hi <= wdata;
        `PSFS_OFF_PB_LO: pb_lo <= wdata;
        `PSFS_OFF_PB_HI: pb_hi <= wdata;
        `PSFS_OFF_PC_LO: pc_lo <= wdata;
        `PSFS_OFF_PC_HI: pc_hi <= wdata & `PSFS_PC_HI_MASK;
        `PSFS_OFF_PA_DATA: pa_data <= wdata;
        `PSFS_OFF_PA_DIR: pa_dir <= wdata;
        `PSFS_OFF_PB_DATA: pb_data <= wdata;
        `PSFS_OFF_PB_DIR: pb_dir <= wdata;
        `PSFS_OFF_PC_DATA: pc_data <= wdata & `PSFS_PC_MASK;
        `PSFS_OFF_PC_DIR: pc_dir <= wdata & `PSFS_PC_MASK;
        `PSFS_OFF_PA_WAKE: pa_wake <= wdata;
        default: pa_wake <= pa_wake;
      endcase
    end
  end

  // ==========================================================
  // Reads
  always @(posedge clk)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `PSFS_OFF_IRS_B: rdata <= irs_b;
        `PSFS_OFF_IRS_C: rdata <= irs_c;
        `PSFS_OFF_PA_LO: rdata <= pa_lo;
        `PSFS_OFF_PA_HI: rdata <= pa_hi;
        `PSFS_OFF_PB_LO: rdata <= pb_lo;
        `PSFS_OFF_PB_HI: rdata <= pb_hi;
        `PSFS_OFF_PC_LO: rdata <= pc_lo;
        `PSFS_OFF_PC_HI: rdata <= pc_hi;
        `PSFS_OFF_PA_DATA: rdata <= pa_data;
        `PSFS_OFF_PA_DIR: rdata <= pa_dir;
        `PSFS_OFF_PB_DATA: rdata <= pb_data;
        `PSFS_OFF_PB_DIR: rdata <= pb_dir;
        `PSFS_OFF_PC_DATA: rdata <= pc_data;
        `PSFS_OFF_PC_DIR: rdata <= pc_dir;
        `PSFS_OFF_PA_WAKE: rdata <= pa_wake;
        default: rdata <= pins_a ^ pins_b ^ pins_c;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// *** rtl/psfs_top.v ***
// Pin shared function select: input routing and per-pin output function muxes.
// Assumes pins and peripheral signals are synchronous to clk.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "psfs_consts.vh"
module psfs_top
(
  input wire clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire [7:0] pa_in,
  input wire [7:0] pb_in,
  input wire [5:0] pc_in,
  output reg [7:0] pa_out,
  output reg [7:0] pa_oe,
  output reg [7:0] pb_out,
  output reg [7:0] pb_oe,
  output reg [5:0] pc_out,
  output reg [5:0] pc_oe,
  output reg [7:0] pa_analog_sel,
  output reg [7:0] pb_analog_sel,
  output reg [5:0] pc_analog_sel,
  input wire std_timer_out,
  input wire per_timer_out,
  input wire serial_chip_select_out,
  input wire serial_chip_select_oe,
  input wire serial_clock_out,
  input wire serial_clock_oe,
  input wire serial_out_uart_tx,
  input wire serial_in_oe,
  input wire serial_in_drive,
  output reg std_timer_capture_in,
  output reg per_timer_capture_in,
  output reg std_timer_clock_in,
  output reg per_timer_clock_in,
  output reg ext_interrupt_a,
  output reg ext_interrupt_b,
  output reg serial_chip_select_in,
  output reg serial_clock_in,
  output reg serial_in_uart_rx,
  input wire sleep_mode,
  output reg wake_req
);
  // ==========================================================
  // Register file
  wire [7:0] irs_b;
  wire [7:0] irs_c;
  wire [7:0] pa_lo;
  wire [7:0] pa_hi;
  wire [7:0] pb_lo;
  wire [7:0] pb_hi;
  wire [7:0] pc_lo;
  wire [7:0] pc_hi;
  wire [7:0] pa_data;
  wire [7:0] pa_dir;
  wire [7:0] pb_data;
  wire [7:0] pb_dir;
  wire [7:0] pc_data;
  wire [7:0] pc_dir;
  wire [7:0] pa_wake;
  wire std_timer_out_inverted;
  wire per_timer_out_inverted;
  assign std_timer_out_inverted = ~std_timer_out;
  assign per_timer_out_inverted = ~per_timer_out;

  psfs_regs u_regs
  (
    .clk(clk),
    .nrst(nrst),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .wr(reg_wr),
    .rd(reg_rd),
    .pins_a(pa_in),
    .pins_b(pb_in),
    .pins_c({2'b00, pc_in}),
    .rdata(reg_rdata),
    .irs_b(irs_b),
    .irs_c(irs_c),
    .pa_lo(pa_lo),
    .pa_hi(pa_hi),
    .pb_lo(pb_lo),
    .pb_hi(pb_hi),
    .pc_lo(pc_lo),
    .pc_hi(pc_hi),
    .pa_data(pa_data),
    .pa_dir(pa_dir),
    .pb_data(pb_data),
    .pb_dir(pb_dir),
    .pc_data(pc_data),
    .pc_dir(pc_dir),
    .pa_wake(pa_wake)
  );

  // ==========================================================
  // Per-pin function word: {analog, alt_oe, alt_value}
  // alt_oe high means a peripheral drives the pin; analog high isolates it
  function [2:0] fsel;
    input [1:0] code;
    input [2:0] f00;
    input [2:0] f01;
    input [2:0] f10;
    input [2:0] f11;
    begin
      case (code)
        `PSFS_C00: fsel = f00;
        `PSFS_C01: fsel = f01;
        `PSFS_C10: fsel = f10;
        default: fsel = f11;
      endcase
    end
  endfunction

  wire [2:0] gp;
  wire [2:0] an;
  wire [2:0] sto;
  wire [2:0] stb;
  wire [2:0] pto;
  wire [2:0] ptb;
  wire [2:0] serial_chip_select;
  wire [2:0] sck;
  wire [2:0] sdo;
  wire [2:0] sdi;
  assign gp = 3'b000;
  assign an = 3'b100;
  assign sto = {2'b01, std_timer_out};
  assign stb = {2'b01, std_timer_out_inverted};
  assign pto = {2'b01, per_timer_out};
  assign ptb = {2'b01, per_timer_out_inverted};
  assign serial_chip_select = {1'b0, serial_chip_select_oe, serial_chip_select_out};
  assign sck = {1'b0, serial_clock_oe, serial_clock_out};
  assign sdo = {2'b01, serial_out_uart_tx};
  assign sdi = {1'b0, serial_in_oe, serial_in_drive};

  reg [2:0] fa [0:7];
  reg [2:0] fb [0:7];
  reg [2:0] fc [0:5];

  always @*
  begin
    fa[0] = fsel(pa_lo[1:0], gp, serial_chip_select, sdi, gp);
    fa[1] = fsel(pa_lo[3:2], gp, sdi, ptb, an);
    fa[2] = fsel(pa_lo[5:4], gp, sck, sdo, gp);
    fa[3] = fsel(pa_lo[7:6], gp, pto, serial_chip_select, sdo);
    fa[4] = fsel(pa_hi[1:0], gp, sdo, sck, ptb);
    fa[5] = fsel(pa_hi[3:2], gp, pto, sdi, gp);
    fa[6] = fsel(pa_hi[5:4], gp, ptb, serial_chip_select, sdo);
    fa[7] = fsel(pa_hi[7:6], gp, sdo, sck, gp);
    fb[0] = fsel(pb_lo[1:0], gp, serial_chip_select, an, stb);
    fb[1] = fsel(pb_lo[3:2], gp, sdo, ptb, an);
    fb[2] = fsel(pb_lo[5:4], gp, pto, an, gp);
    fb[3] = fsel(pb_lo[7:6], gp, an, an, gp);
    fb[4] = fsel(pb_hi[1:0], gp, sdi, sto, gp);
    fb[5] = fsel(pb_hi[3:2], gp, sdo, sck, gp);
    fb[6] = fsel(pb_hi[5:4], gp, pto, an, gp);
    fb[7] = fsel(pb_hi[7:6], gp, sdo, an, gp);
    fc[0] = fsel(pc_lo[1:0], gp, pto, gp, gp);
    fc[1] = fsel(pc_lo[3:2], gp, sdo, gp, gp);
    fc[2] = fsel(pc_lo[5:4], gp, ptb, gp, gp);
    fc[3] = fsel(pc_lo[7:6], gp, sto, gp, gp);
    fc[4] = fsel(pc_hi[1:0], gp, stb, gp, gp);
    fc[5] = fsel(pc_hi[3:2], gp, sdo, an, gp);
  end

  // ==========================================================
  // Registered pin drivers
  wire [7:0] pa_out_d;
  wire [7:0] pa_oe_d;
  wire [7:0] pa_an_d;
  wire [7:0] pb_out_d;
  wire [7:0] pb_oe_d;
  wire [7:0] pb_an_d;
  wire [5:0] pc_out_d;
  wire [5:0] pc_oe_d;
  wire [5:0] pc_an_d;

  // Next pin state per bit from the function word
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_ab
      assign pa_an_d[i] = fa[i][2];
      assign pa_out_d[i] = fa[i][1] ? fa[i][0] : pa_data[i];
      assign pa_oe_d[i] = ~fa[i][2] & (fa[i][1] | ~pa_dir[i]);
      assign pb_an_d[i] = fb[i][2];
      assign pb_out_d[i] = fb[i][1] ? fb[i][0] : pb_data[i];
      assign pb_oe_d[i] = ~fb[i][2] & (fb[i][1] | ~pb_dir[i]);
    end
    for (i = 0; i < 6; i = i + 1)
    begin : g_c
      assign pc_an_d[i] = fc[i][2];
      assign pc_out_d[i] = fc[i][1] ? fc[i][0] : pc_data[i];
      assign pc_oe_d[i] = ~fc[i][2] & (fc[i][1] | ~pc_dir[i]);
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pa_out <= `PSFS_PORT_RST;
      pa_oe <= 8'h00;
      pa_analog_sel <= 8'h00;
    end
    else
    begin
      pa_out <= pa_out_d;
      pa_oe <= pa_oe_d;
      pa_analog_sel <= pa_an_d;
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pb_out <= `PSFS_PORT_RST;
      pb_oe <= 8'h00;
      pb_analog_sel <= 8'h00;
    end
    else
    begin
      pb_out <= pb_out_d;
      pb_oe <= pb_oe_d;
      pb_analog_sel <= pb_an_d;
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pc_out <= 6'h3F;
      pc_oe <= 6'h00;
      pc_analog_sel <= 6'h00;
    end
    else
    begin
      pc_out <= pc_out_d;
      pc_oe <= pc_oe_d;
      pc_analog_sel <= pc_an_d;
    end
  end

  // ==========================================================
  // Input routing to peripherals
  // One of four source pins chosen by a 2-bit code
  function pick4;
    input [1:0] code;
    input [3:0] src;
    begin
      case (code)
        `PSFS_C00: pick4 = src[0];
        `PSFS_C01: pick4 = src[1];
        `PSFS_C10: pick4 = src[2];
        default: pick4 = src[3];
      endcase
    end
  endfunction

  reg std_cap_d;
  reg per_cap_d;
  reg std_clk_d;
  reg per_clk_d;
  reg int_a_d;
  reg int_b_d;
  reg scs_d;
  reg sck_d;
  reg sdi_d;
  reg wake_d;
  // Pin levels one clock back, for falling-edge detection
  reg [7:0] pa_prev_q;

  // Next values of the routed inputs and the wake request
  always @*
  begin
    std_cap_d = pick4(irs_b[7:6], {pb_in[1], pb_in[1], pa_in[6], pb_in[1]});
    per_cap_d = pick4(irs_b[5:4], {pa_in[4], pa_in[4], pb_in[5], pa_in[4]});
    int_b_d = pick4(irs_b[3:2], {pb_in[0], pb_in[3], pc_in[4], pb_in[6]});
    int_a_d = pick4(irs_b[1:0], {pb_in[0], pa_in[7], pa_in[5], pa_in[1]});
    per_clk_d = pick4(irs_c[1:0], {pa_in[3], pa_in[3], pb_in[4], pa_in[3]});
    std_clk_d = pb_in[2];
    scs_d = pa_in[0];
    sck_d = pa_in[2];
    sdi_d = pa_in[0];
    wake_d = sleep_mode & (|(pa_wake & pa_prev_q & ~pa_in));
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      std_timer_capture_in <= 1'b0;
      per_timer_capture_in <= 1'b0;
      std_timer_clock_in <= 1'b0;
      per_timer_clock_in <= 1'b0;
      ext_interrupt_a <= 1'b0;
      ext_interrupt_b <= 1'b0;
      serial_chip_select_in <= 1'b0;
      serial_clock_in <= 1'b0;
      serial_in_uart_rx <= 1'b0;
      pa_prev_q <= `PSFS_PORT_RST;
      wake_req <= 1'b0;
    end
    else
    begin
      std_timer_capture_in <= std_cap_d;
      per_timer_capture_in <= per_cap_d;
      std_timer_clock_in <= std_clk_d;
      per_timer_clock_in <= per_clk_d;
      ext_interrupt_a <= int_a_d;
      ext_interrupt_b <= int_b_d;
      serial_chip_select_in <= scs_d;
      serial_clock_in <= sck_d;
      serial_in_uart_rx <= sdi_d;
      pa_prev_q <= pa_in;
      wake_req <= wake_d;
    end
  end
endmodule
`default_nettype wire

// *** tb/psfs_sva.sv ***
// Checker for input routing, pin functions, read masks and wake-up.
// Assumes binding to psfs_top: one clock, synchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
module psfs_sva
(
  input wire clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] pa_in,
  input wire [7:0] pb_in,
  input wire [5:0] pc_in,
  input wire [7:0] pa_out,
  input wire [7:0] pa_oe,
  input wire [7:0] pa_analog_sel,
  input wire per_timer_out,
  input wire std_timer_capture_in,
  input wire per_timer_capture_in,
  input wire per_timer_clock_in,
  input wire ext_interrupt_a,
  input wire ext_interrupt_b,
  input wire sleep_mode,
  input wire wake_req
);
  // ==========
  // Register shadow
  logic [7:0] sh_q [0:15];
  logic [7:0] pa_prev_q;
  wire [3:0] ib_v = {pb_in[0], pb_in[3], pc_in[4], pb_in[6]};
  wire [3:0] ia_v = {pb_in[0], pa_in[7], pa_in[5], pa_in[1]};
  wire std_e = sh_q[0][7:6] == 2'b01 ? pa_in[6] : pb_in[1];
  wire per_e = sh_q[0][5:4] == 2'b01 ? pb_in[5] : pa_in[4];
  wire pck_e = sh_q[1][1:0] == 2'b01 ? pb_in[4] : pa_in[3];
  wire fall_w = sleep_mode && |(sh_q[14] & pa_prev_q & ~pa_in);
  always @(posedge clk)
  begin
    pa_prev_q <= nrst ? pa_in : 8'hFF;
    if (!nrst)
    begin
      sh_q[0] <= 8'h00;
      sh_q[1] <= 8'h00;
      sh_q[2] <= 8'h00;
      sh_q[8] <= 8'hFF;
      sh_q[9] <= 8'hFF;
      sh_q[14] <= 8'h00;
    end
    else if (reg_wr)
      sh_q[reg_addr] <= reg_wdata;
  end
  // ==========
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_live;
    $past(nrst);
  endsequence
  a_cap_std: assert property (s_live |-> std_timer_capture_in == $past(std_e))
    else $error("standard capture route wrong");
  a_cap_per: assert property (s_live |-> per_timer_capture_in == $past(per_e))
    else $error("periodic capture route wrong");
  a_int_b: assert property (s_live |-> ext_interrupt_b == $past(ib_v[sh_q[0][3:2]]))
    else $error("interrupt b route wrong");
  a_int_a: assert property (s_live |-> ext_interrupt_a == $past(ia_v[sh_q[0][1:0]]))
    else $error("interrupt a route wrong");
  a_clk_per: assert property (s_live |-> per_timer_clock_in == $past(pck_e))
    else $error("periodic clock route wrong");
  a_rd_mask: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:2] == 6'h00)
    else $error("unused select bits read nonzero");
  a_pa3_timer: assert property (s_live ##0 $past(sh_q[2][7:6]) == 2'b01
    |-> pa_oe[3] && pa_out[3] == $past(per_timer_out))
    else $error("pin a3 timer output wrong");
  a_pa0_port: assert property (s_live ##0 $past(sh_q[2][1] == sh_q[2][0])
    |-> pa_oe[0] == !$past(sh_q[9][0]) && (!pa_oe[0] || pa_out[0] == $past(sh_q[8][0])))
    else $error("pin a0 port function wrong");
  a_pa1_analog: assert property (s_live ##0 $past(sh_q[2][3:2]) == 2'b11
    |-> pa_analog_sel[1] && !pa_oe[1])
    else $error("pin a1 analogue select wrong");
  a_wake_set: assert property (fall_w |-> ##[1:2] wake_req)
    else $error("wake missing after falling edge");
  a_wake_off: assert property (!fall_w [*3] |-> !wake_req)
    else $error("wake without enabled falling edge");
endmodule
`default_nettype wire

// *** tb/psfs_periph.sv ***
// Peripheral model: timer and serial outputs stepping from a counter.
// Assumes one clock with synchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
module psfs_periph
(
  input wire logic clk,
  input wire logic nrst,
  output logic std_timer_out,
  output logic per_timer_out,
  output logic serial_chip_select_out,
  output logic serial_chip_select_oe,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic serial_out_uart_tx,
  output logic serial_in_oe,
  output logic serial_in_drive
);
  // ==========
  // Free counter drives every value output; the three enables are tied high
  logic [3:0] cnt_q;
  always @(posedge clk)
    cnt_q <= nrst ? cnt_q + 4'h1 : 4'h0;
  assign std_timer_out = cnt_q[1];
  assign per_timer_out = cnt_q[2];
  assign serial_chip_select_out = cnt_q[0];
  assign serial_chip_select_oe = 1'b1;
  assign serial_clock_out = cnt_q[3];
  assign serial_clock_oe = 1'b1;
  assign serial_out_uart_tx = cnt_q[1] ^ cnt_q[3];
  assign serial_in_oe = 1'b1;
  assign serial_in_drive = cnt_q[2] ^ cnt_q[0];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench: reset values, masks, routing, pin functions, wake-up.
// Assumes the design header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "psfs_consts.vh"
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  logic [7:0] pa_in = 8'h00;
  logic [7:0] pb_in = 8'h00;
  logic [5:0] pc_in = 6'h00;
  wire [7:0] reg_rdata, pa_out, pa_oe, pb_out, pb_oe, pa_analog_sel, pb_analog_sel;
  wire [5:0] pc_out, pc_oe, pc_analog_sel;
  wire std_timer_out, per_timer_out, serial_chip_select_out, serial_chip_select_oe;
  wire serial_clock_out, serial_clock_oe, serial_out_uart_tx, serial_in_oe, serial_in_drive;
  wire std_timer_capture_in, per_timer_capture_in, std_timer_clock_in, per_timer_clock_in;
  wire ext_interrupt_a, ext_interrupt_b, serial_chip_select_in, serial_clock_in;
  wire serial_in_uart_rx, wake_req;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] rd_v;
  logic [7:0] pa_an [0:3] = '{8'h00, 8'h00, 8'h00, 8'h02};
  logic [7:0] pb_an [0:3] = '{8'h00, 8'h08, 8'hCD, 8'h02};
  logic [5:0] pc_an [0:3] = '{6'h00, 6'h00, 6'h20, 6'h00};
  always #10 clk = ~clk;
  psfs_top psfs_top_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pa_in, .pb_in, .pc_in, .pa_out, .pa_oe, .pb_out, .pb_oe, .pc_out, .pc_oe,
    .pa_analog_sel, .pb_analog_sel, .pc_analog_sel, .std_timer_out, .per_timer_out,
    .serial_chip_select_out, .serial_chip_select_oe, .serial_clock_out, .serial_clock_oe,
    .serial_out_uart_tx, .serial_in_oe, .serial_in_drive, .std_timer_capture_in,
    .per_timer_capture_in, .std_timer_clock_in, .per_timer_clock_in, .ext_interrupt_a,
    .ext_interrupt_b, .serial_chip_select_in, .serial_clock_in, .serial_in_uart_rx,
    .sleep_mode, .wake_req);
  psfs_periph psfs_periph_inst (.clk, .nrst, .std_timer_out, .per_timer_out,
    .serial_chip_select_out, .serial_chip_select_oe, .serial_clock_out, .serial_clock_oe,
    .serial_out_uart_tx, .serial_in_oe, .serial_in_drive);
  // ==========
  // Tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic route(input logic [1:0] c, input logic [7:0] p);
    logic [3:0] ib;
    logic [3:0] ia;
    logic [4:0] e;
    wr(`PSFS_OFF_IRS_B, {c, c, c, c});
    wr(`PSFS_OFF_IRS_C, {6'h00, c});
    pa_in <= p;
    pb_in <= ~p;
    pc_in <= p[5:0];
    repeat (2) @(posedge clk);
    #1;
    ib = {pb_in[0], pb_in[3], pc_in[4], pb_in[6]};
    ia = {pb_in[0], pa_in[7], pa_in[5], pa_in[1]};
    e = {c == 2'b01 ? pa_in[6] : pb_in[1], c == 2'b01 ? pb_in[5] : pa_in[4], ib[c], ia[c],
      c == 2'b01 ? pb_in[4] : pa_in[3]};
    chk("route", {std_timer_capture_in, per_timer_capture_in, ext_interrupt_b,
      ext_interrupt_a, per_timer_clock_in}, e);
    chk("fixed", {4'h0, std_timer_clock_in, serial_chip_select_in, serial_clock_in,
      serial_in_uart_rx}, {4'h0, pb_in[2], pa_in[0], pa_in[2], pa_in[0]});
  endtask
  task automatic outs(input logic [1:0] c);
    logic [2:0] sv;
    for (int a = 2; a < 8; a++)
      wr(a[3:0], {c, c, c, c});
    @(posedge clk);
    #1;
    sv = {std_timer_out, per_timer_out, serial_out_uart_tx};
    @(posedge clk);
    #1;
    chk("pa_an", pa_analog_sel, pa_an[c]);
    chk("pb_an", pb_analog_sel, pb_an[c]);
    chk("pc_an", {2'b00, pc_analog_sel}, {2'b00, pc_an[c]});
    chk("pa_oe", pa_oe, ~pa_an[c]);
    chk("pb_oe", pb_oe, ~pb_an[c]);
    chk("pc_oe", {2'b00, pc_oe}, {2'b00, ~pc_an[c]});
    chk("pc_out", {4'h0, pc_out[3:0]},
      {4'h0, c == 2'b01 ? {sv[2], ~sv[1], sv[0], sv[1]} : 4'h5});
  endtask
  task automatic wake(input logic [7:0] p, input logic [7:0] e);
    int n;
    pa_in <= 8'hFF;
    @(posedge clk);
    pa_in <= p;
    n = 0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      if (wake_req === 1'b1)
        n++;
    end
    chk("wake", n[7:0], e);
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 15; a++)
    begin
      rd(a[3:0]);
      chk("reset", rd_v, a < 8 ? 8'h00 : a < 12 ? 8'hFF : a < 14 ? 8'h3F : 8'h00);
    end
    chk("pa_oe", pa_oe, 8'h00);
    chk("pa_out", pa_out, 8'hFF);
    for (int a = 0; a < 8; a++)
    begin
      wr(a[3:0], 8'hFF);
      rd(a[3:0]);
      chk("mask", rd_v, a == 1 ? 8'h03 : a == 7 ? 8'h0F : 8'hFF);
    end
    wr(`PSFS_OFF_PA_DIR, 8'hFF);
    for (int c = 0; c < 4; c++)
    begin
      route(c[1:0], 8'hA5);
      route(c[1:0], 8'h5A);
    end
    for (int a = 8; a < 14; a++)
      wr(a[3:0], a[0] ? 8'h00 : 8'h55);
    for (int c = 3; c >= 0; c--)
      outs(c[1:0]);
    chk("pa_out", pa_out, 8'h55);
    chk("pb_out", pb_out, 8'h55);
    chk("pc_out", {2'b00, pc_out}, 8'h15);
    wr(`PSFS_OFF_PA_DIR, 8'hFF);
    @(posedge clk);
    #1;
    chk("pa_oe", pa_oe, 8'h00);
    wr(`PSFS_OFF_PA_WAKE, 8'h11);
    sleep_mode <= 1'b1;
    wake(8'hEF, 8'h01);
    wake(8'hFD, 8'h00);
    wake(8'hEE, 8'h01);
    sleep_mode <= 1'b0;
    wake(8'hEF, 8'h00);
    stop_test;
  end
  // Cut a hang at many times the normal run
  initial
  begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
bind psfs_top psfs_sva psfs_sva_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pa_in, .pb_in, .pc_in, .pa_out, .pa_oe, .pa_analog_sel, .per_timer_out,
  .std_timer_capture_in, .per_timer_capture_in, .per_timer_clock_in, .ext_interrupt_a,
  .ext_interrupt_b, .sleep_mode, .wake_req);
`default_nettype wire
